/* src/cod_cfg.svh */
`ifndef COD_CFG_SVH
`define COD_CFG_SVH
// Memory sizes and address counter width.
`define COD_TEXT_DEPTH 128
`define COD_GLYPH_DEPTH 64
`define COD_AC_W 7
`define COD_GLYPH_AW 6
// Transfer buffer shape: one entry is {select, direction, byte}.
`define COD_FIFO_DEPTH 16
`define COD_ENTRY_W 10
// Synchronised pins: serial clock, serial data, chip select, select, direction, enable, bus.
`define COD_SYNC_W 14
// Character written into every text cell by the blanking command.
`define COD_BLANK_CHAR 8'h20
// Longest allowed blanking time and the clock period, both in ns.
`define COD_CLR_MAX_NS 6200000
`define COD_CLK_NS 20
// Command opcode prefixes, compared against the top bits of the byte; the SUB values against the low two bits.
`define COD_OP_CLEAR 8'h01
`define COD_OP_HOME 7'h01
`define COD_OP_ENTRY 6'h01
`define COD_OP_DISP 5'h01
`define COD_OP_SHIFT 4'h1
`define COD_OP_FUNC 3'h1
`define COD_OP_GLYPH 2'h1
`define COD_SUB_MOVE 2'h0
`define COD_SUB_MODE 2'h3
// Field positions inside command bytes.
`define COD_B_ID 1
`define COD_B_S 0
`define COD_B_D 2
`define COD_B_C 1
`define COD_B_B 0
`define COD_B_SC 3
`define COD_B_RL 2
`define COD_B_GC 3
`define COD_B_PWR 2
`define COD_B_DL 4
`define COD_B_N 3
`define COD_B_F 2
`define COD_B_ADDR7 7
// Serial frame: select bit, direction bit, then eight data bits.
`define COD_SER_RWIDX 4'h1
`define COD_SER_LAST 4'h9
// Reset values of the settings, and the font table code of the western set.
`define COD_RST_IWIDTH 1'b1
`define COD_RST_INC 1'b1
`define COD_RST_FONT 2'h0
`define COD_FT_WESTERN 2'h1
`endif

/* src/cod_pkg.sv */
package cod_pkg;
  // Executor states.
  typedef enum logic {COD_IDLE, COD_CLEAR} cod_state_t;
  typedef logic [7:0] cod_byte_t;
endpackage

/* src/cod_sync.sv */
`timescale 1ns/1ps
module cod_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [W-1:0] d_i, // Asynchronous inputs.
  output logic [W-1:0] q_o // Synchronised outputs.
);
  genvar g;
  // Two flip-flops per bit; only the second stage is visible outside.
  for (g = 0; g < W; g++) begin : g_bit
    logic meta;
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        meta <= 1'b0;
        q_o[g] <= 1'b0;
      end else begin
        meta <= d_i[g];
        q_o[g] <= meta;
      end
    end
  end
endmodule

/* src/cod_fifo.sv */
`timescale 1ns/1ps
module cod_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Not full.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  output logic out_valid_o, // Not empty.
  input wire logic out_ready_i, // Drain accepts the head entry.
  output logic [WIDTH-1:0] out_data_o // Head entry.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Pointers carry one extra bit so full and empty are told apart.
  assign in_ready_o = (wr_ptr[AW] == rd_ptr[AW]) ||
                      (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer update.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Storage has no reset; an entry is only read after it was written.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

/* src/cod_decoder.sv */
`timescale 1ns/1ps
`include "cod_cfg.svh"
// How it works
// - Byte 01 blanks all text cells and zeroes the address, well inside 6.2ms.
// - Return home zeroes the address and display shift, text stays intact.
// - Entry mode stores direction and shift-on-access for later data accesses.
// - Display control stores display, cursor and blink enables.
// - Shift command with low bits 00 moves cursor or shifts display.
// - Shift command with low bits 11 sets graphic mode and internal power.
// - Function set stores width, line count, font size and font table.
// - Glyph address command loads six bits and targets glyph memory.
// - Text address command loads seven bits and targets text memory.
// - Status read returns busy on bit 7 and the address below it.
// - Data write stores into the last addressed memory at the address.
// - Data read returns the last addressed memory byte at the address.
// - While busy only the status read is served; the host polls busy.
// - Every data access steps the address up or down by one.
// - Font table value 01 selects the western European set.
module cod_decoder #(
  parameter int TEXT_DEPTH = `COD_TEXT_DEPTH,
  parameter int GLYPH_DEPTH = `COD_GLYPH_DEPTH,
  parameter int FIFO_DEPTH = `COD_FIFO_DEPTH
) (
  input wire logic mclk_i, // System clock, 50 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic bus_style_i, // 0 enable strobe, 1 read/write strobes.
  input wire logic serial_mode_i, // 1 selects the serial link.
  input wire logic chip_select_n_i, // Chip select, active low.
  input wire logic register_select_i, // 0 command/status, 1 data.
  input wire logic enable_or_read_strobe_i, // Enable, or read strobe low.
  input wire logic rw_or_write_strobe_i, // Direction, or write strobe low.
  input wire logic [7:0] data_i, // Parallel bus input level.
  output logic [7:0] data_o, // Parallel bus drive value.
  output logic data_oe_o, // High while the bus is driven.
  input wire logic serial_clk_i, // Serial clock from the host.
  input wire logic serial_data_in_i, // Serial data from the host.
  output logic serial_data_out_o, // Serial read data.
  input wire logic [6:0] panel_addr_i, // Text cell wanted by the panel.
  output logic [7:0] panel_char_o, // Text cell contents.
  output logic busy_o, // Busy flag copy.
  output logic [6:0] address_counter_o, // Address counter.
  output logic glyph_target_o, // 1 when glyph memory is addressed.
  output logic [6:0] display_shift_o, // Display shift offset.
  output logic increment_direction_o, // 1 counts up.
  output logic shift_on_access_o, // Display shifts on data access.
  output logic display_on_o, // Display enable.
  output logic cursor_on_o, // Cursor enable.
  output logic cursor_blink_o, // Cursor blink enable.
  output logic graphic_char_select_o, // 1 graphic mode.
  output logic internal_power_on_o, // Internal power enable.
  output logic interface_width_o, // 1 eight-bit, 0 four-bit bus.
  output logic line_count_select_o, // Number of lines select.
  output logic font_size_select_o, // Font size select.
  output logic [1:0] font_table_select_o, // Font table select.
  output logic western_set_o // Western European set selected.
);
  localparam int CLR_LIMIT = `COD_CLR_MAX_NS / `COD_CLK_NS;
  localparam logic [6:0] CLR_LAST = 7'(TEXT_DEPTH - 1);

  cod_pkg::cod_byte_t text_mem [TEXT_DEPTH];
  cod_pkg::cod_byte_t glyph_mem [GLYPH_DEPTH];
  cod_pkg::cod_state_t state;
  logic [`COD_SYNC_W-1:0] sync;
  logic s_sclk, s_sdi, s_csn, s_rs, s_rw, s_e, pop, is_cmd, is_wr, is_rd;
  logic [7:0] s_d, so_sh, ev_byte, c, status_val;
  logic primed, p_e, p_rw, p_sclk, par_done, par_read, par_drive, nib_phase;
  logic [3:0] nib_hi, ser_cnt;
  logic [8:0] ser_sr;
  logic ev, ev_rs, ev_rw, busy_now, in_ready, out_valid, out_ready;
  logic [`COD_ENTRY_W-1:0] head;
  logic [6:0] clr_idx;
  cod_pkg::cod_byte_t read_latch;

  // A blanking pass of one cell per clock must fit the allowed time.
  if (TEXT_DEPTH > CLR_LIMIT) begin : g_too_deep
    $error("Text memory too deep to blank in time.");
  end
  // Every pin from the host passes two flip-flops first.
  cod_sync #(.W(`COD_SYNC_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i({serial_clk_i, serial_data_in_i, chip_select_n_i,
          register_select_i, rw_or_write_strobe_i,
          enable_or_read_strobe_i, data_i}),
    .q_o(sync)
  );
  assign {s_sclk, s_sdi, s_csn, s_rs, s_rw, s_e, s_d} = sync;

  // Previous strobe levels; edges count only once these hold real samples.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      primed <= 1'b0;
      p_e <= 1'b0;
      p_rw <= 1'b0;
      p_sclk <= 1'b0;
    end else begin
      primed <= 1'b1;
      p_e <= s_e;
      p_rw <= s_rw;
      p_sclk <= s_sclk;
    end
  end

  // Parallel transfer end and read drive window for the two strobe styles.
  always_comb begin
    if (bus_style_i) begin
      par_done = primed && !s_csn && ((!p_rw && s_rw) || (!p_e && s_e));
      par_read = !p_e && s_e;
      par_drive = !s_csn && !s_e;
    end else begin
      par_done = primed && !s_csn && p_e && !s_e;
      par_read = s_rw;
      par_drive = !s_csn && s_e && s_rw;
    end
  end

  // Status byte seen by the host: busy on top, address below.
  assign busy_now = (state == cod_pkg::COD_CLEAR) || !in_ready;
  assign status_val = {busy_now, address_counter_o};

  // Nibble pairing in four-bit mode: high nibble first on the top lines.
  always_ff @(posedge mclk_i) begin
    if (rst_i || serial_mode_i || interface_width_o) begin
      nib_phase <= 1'b0;
      nib_hi <= 4'h0;
    end else if (par_done) begin
      nib_phase <= !nib_phase;
      nib_hi <= s_d[7:4];
    end
  end

  // Serial frame shifter; chip select high aborts a partial frame.
  always_ff @(posedge mclk_i) begin
    if (rst_i || s_csn || !serial_mode_i) begin
      ser_cnt <= 4'h0;
      ser_sr <= 9'h000;
      so_sh <= 8'h00;
      serial_data_out_o <= 1'b0;
    end else if (primed && s_sclk && !p_sclk) begin
      ser_sr <= {ser_sr[7:0], s_sdi};
      ser_cnt <= (ser_cnt == `COD_SER_LAST) ? 4'h0 : ser_cnt + 4'h1;
      if (ser_cnt == `COD_SER_RWIDX && s_sdi) begin
        so_sh <= ser_sr[0] ? read_latch : status_val;
        serial_data_out_o <= ser_sr[0] ? read_latch[7] : status_val[7];
      end else begin
        so_sh <= {so_sh[6:0], 1'b0};
        serial_data_out_o <= so_sh[6];
      end
    end
  end

  // One completed transfer from whichever link is active.
  always_comb begin
    if (serial_mode_i) begin
      ev = primed && !s_csn && s_sclk && !p_sclk &&
           (ser_cnt == `COD_SER_LAST);
      ev_rs = ser_sr[8];
      ev_rw = ser_sr[7];
      ev_byte = {ser_sr[6:0], s_sdi};
    end else begin
      ev = par_done && (interface_width_o || nib_phase);
      ev_rs = s_rs;
      ev_rw = par_read;
      ev_byte = interface_width_o ? s_d : {nib_hi, s_d[7:4]};
    end
  end

  // Parallel read data; the latch is valid at the start of the cycle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= par_drive && !serial_mode_i;
      if (!interface_width_o && nib_phase) begin
        data_o <= {(s_rs ? read_latch[3:0] : status_val[3:0]), 4'h0};
      end else begin
        data_o <= s_rs ? read_latch : status_val;
      end
    end
  end

  // Status reads are answered at the pins and never queued.
  cod_fifo #(.WIDTH(`COD_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(ev && (ev_rs || !ev_rw) && !busy_now),
    .in_ready_o(in_ready),
    .in_data_i({ev_rs, ev_rw, ev_byte}),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready),
    .out_data_o(head)
  );

  // Execution decode; the drain stalls while blanking runs.
  assign out_ready = (state == cod_pkg::COD_IDLE);
  assign pop = out_valid && out_ready;
  assign c = head[7:0];
  assign is_cmd = pop && !head[9] && !head[8];
  assign is_wr = pop && head[9] && !head[8];
  assign is_rd = pop && head[9] && head[8];

  // Blanking sequencer, one cell per clock.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= cod_pkg::COD_IDLE;
      clr_idx <= 7'h00;
    end else begin
      unique case (state)
        cod_pkg::COD_IDLE: begin
          clr_idx <= 7'h00;
          if (is_cmd && c == `COD_OP_CLEAR) begin
            state <= cod_pkg::COD_CLEAR;
          end
        end
        cod_pkg::COD_CLEAR: begin
          clr_idx <= clr_idx + 7'h01;
          if (clr_idx == CLR_LAST) begin
            state <= cod_pkg::COD_IDLE;
          end
        end
      endcase
    end
  end

  // Memory writes: blanking, or data into the memory last addressed.
  always_ff @(posedge mclk_i) begin
    if (state == cod_pkg::COD_CLEAR) begin
      text_mem[clr_idx] <= `COD_BLANK_CHAR;
    end else if (is_wr && !glyph_target_o) begin
      text_mem[address_counter_o] <= c;
    end
    if (is_wr && glyph_target_o) begin
      glyph_mem[address_counter_o[`COD_GLYPH_AW-1:0]] <= c;
    end
  end

  // Prefetch so a read answers in the same strobe it is asked.
  always_ff @(posedge mclk_i) begin
    read_latch <= glyph_target_o ?
      glyph_mem[address_counter_o[`COD_GLYPH_AW-1:0]] :
      text_mem[address_counter_o];
    panel_char_o <= text_mem[panel_addr_i];
  end

  // Address counter, memory target and display shift.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      address_counter_o <= 7'h00;
      glyph_target_o <= 1'b0;
      display_shift_o <= 7'h00;
    end else if (is_cmd && (c == `COD_OP_CLEAR ||
                 c[7:1] == `COD_OP_HOME)) begin
      address_counter_o <= 7'h00;
      glyph_target_o <= 1'b0;
      display_shift_o <= 7'h00;
    end else if (is_cmd && c[`COD_B_ADDR7]) begin
      address_counter_o <= c[6:0];
      glyph_target_o <= 1'b0;
    end else if (is_cmd && c[7:6] == `COD_OP_GLYPH) begin
      address_counter_o <= {1'b0, c[5:0]};
      glyph_target_o <= 1'b1;
    end else if (is_cmd && c[7:4] == `COD_OP_SHIFT &&
                 c[1:0] == `COD_SUB_MOVE) begin
      if (c[`COD_B_SC]) begin
        display_shift_o <= c[`COD_B_RL] ? display_shift_o + 7'h01 :
                           display_shift_o - 7'h01;
      end else begin
        address_counter_o <= c[`COD_B_RL] ? address_counter_o + 7'h01 :
                             address_counter_o - 7'h01;
      end
    end else if (is_wr || is_rd) begin
      // Glyph addressing wraps inside its six-bit space.
      address_counter_o <= increment_direction_o ?
        address_counter_o + 7'h01 : address_counter_o - 7'h01;
      if (glyph_target_o) begin
        address_counter_o[`COD_AC_W-1] <= 1'b0;
      end
      if (shift_on_access_o) begin
        display_shift_o <= increment_direction_o ? display_shift_o - 7'h01
                           : display_shift_o + 7'h01;
      end
    end
  end

  // Settings registers; a clear also restores upward counting.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      increment_direction_o <= `COD_RST_INC;
      shift_on_access_o <= 1'b0;
      display_on_o <= 1'b0;
      cursor_on_o <= 1'b0;
      cursor_blink_o <= 1'b0;
      graphic_char_select_o <= 1'b0;
      internal_power_on_o <= 1'b0;
      interface_width_o <= `COD_RST_IWIDTH;
      line_count_select_o <= 1'b0;
      font_size_select_o <= 1'b0;
      font_table_select_o <= `COD_RST_FONT;
    end else if (is_cmd) begin
      if (c == `COD_OP_CLEAR) begin
        increment_direction_o <= `COD_RST_INC;
      end
      if (c[7:2] == `COD_OP_ENTRY) begin
        increment_direction_o <= c[`COD_B_ID];
        shift_on_access_o <= c[`COD_B_S];
      end
      if (c[7:3] == `COD_OP_DISP) begin
        display_on_o <= c[`COD_B_D];
        cursor_on_o <= c[`COD_B_C];
        cursor_blink_o <= c[`COD_B_B];
      end
      if (c[7:4] == `COD_OP_SHIFT && c[1:0] == `COD_SUB_MODE) begin
        graphic_char_select_o <= c[`COD_B_GC];
        internal_power_on_o <= c[`COD_B_PWR];
      end
      if (c[7:5] == `COD_OP_FUNC) begin
        interface_width_o <= c[`COD_B_DL];
        line_count_select_o <= c[`COD_B_N];
        font_size_select_o <= c[`COD_B_F];
        font_table_select_o <= c[1:0];
      end
    end
  end

  // Character set decode and busy copy for the panel side.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      western_set_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      western_set_o <= (font_table_select_o == `COD_FT_WESTERN);
      busy_o <= busy_now;
    end
  end
endmodule

/* test/cod_decoder_props.sv */
`timescale 1ns/1ps
module cod_decoder_props (
  input wire logic mclk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic bus_style_i, // Style.
  input wire logic serial_mode_i, // Serial.
  input wire logic chip_select_n_i, // Select.
  input wire logic register_select_i, // Kind.
  input wire logic enable_or_read_strobe_i, // Enable.
  input wire logic rw_or_write_strobe_i, // Direction.
  input wire logic [7:0] data_i, // Bus in.
  input wire logic data_oe_o, // Drive.
  input wire logic busy_o, // Busy.
  input wire logic [6:0] address_counter_o, // Address.
  input wire logic glyph_target_o, // Target.
  input wire logic [6:0] display_shift_o, // Shift.
  input wire logic increment_direction_o, // Up.
  input wire logic shift_on_access_o, // Shift mode.
  input wire logic display_on_o, // Display.
  input wire logic cursor_on_o, // Cursor.
  input wire logic cursor_blink_o, // Blink.
  input wire logic interface_width_o, // Width.
  input wire logic line_count_select_o, // Lines.
  input wire logic font_size_select_o, // Size.
  input wire logic [1:0] font_table_select_o, // Table.
  input wire logic western_set_o // Western.
);
  logic en_q;
  logic [7:0] cmd_q;
  logic [7:0] busy_cnt;
  logic take;

  // A command is taken the cycle after enable falls; busy ones are dropped.
  assign take = en_q && !enable_or_read_strobe_i && !chip_select_n_i &&
    !register_select_i && !rw_or_write_strobe_i && !bus_style_i &&
    !serial_mode_i && interface_width_o && !busy_o;

  // Previous enable level, for spotting the fall.
  always_ff @(posedge mclk_i) begin
    en_q <= rst_i ? 1'b0 : enable_or_read_strobe_i;
  end

  // Keeps the command byte, since the host may change the bus afterwards.
  always_ff @(posedge mclk_i) begin
    if (take) begin
      cmd_q <= data_i;
    end
  end

  // Length of a busy stretch; saturates so a stuck flag cannot wrap it.
  always_ff @(posedge mclk_i) begin
    if (rst_i || !busy_o) begin
      busy_cnt <= 8'h00;
    end else if (busy_cnt != 8'hff) begin
      busy_cnt <= busy_cnt + 8'h01;
    end
  end

  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_clear_busy: assert property (
    take && data_i == 8'h01 |-> ##[1:8] busy_o)
    else $error("Blanking did not raise busy.");
  a_busy_bound: assert property (
    busy_cnt < 8'h8c)
    else $error("Busy stayed high too long.");
  a_home_zero: assert property (
    take && data_i[7:1] == 7'h01 |-> ##[3:8] (address_counter_o == 7'h00
    && display_shift_o == 7'h00 && !glyph_target_o))
    else $error("Return home left address or shift.");
  a_entry_fields: assert property (
    take && data_i[7:2] == 6'h01 |-> ##[3:8]
    {increment_direction_o, shift_on_access_o} == cmd_q[1:0])
    else $error("Entry mode fields not stored.");
  a_disp_fields: assert property (
    take && data_i[7:3] == 5'h01 |-> ##[3:8]
    {display_on_o, cursor_on_o, cursor_blink_o} == cmd_q[2:0])
    else $error("Display control fields not stored.");
  a_func_fields: assert property (
    take && data_i[7:5] == 3'h1 |-> ##[3:8] {interface_width_o,
    line_count_select_o, font_size_select_o, font_table_select_o}
    == cmd_q[4:0])
    else $error("Function set fields not stored.");
  a_western_follow: assert property (
    western_set_o == ($past(font_table_select_o) == 2'h1))
    else $error("Western set flag wrong.");
  a_glyph_range: assert property (
    glyph_target_o |-> !address_counter_o[6])
    else $error("Glyph address beyond six bits.");
  a_write_nodrive: assert property (
    (!bus_style_i && !serial_mode_i && !rw_or_write_strobe_i)[*5]
    |-> !data_oe_o)
    else $error("Bus driven during a write.");
  a_read_drive: assert property (
    !bus_style_i && !serial_mode_i && !chip_select_n_i &&
    rw_or_write_strobe_i && $rose(enable_or_read_strobe_i) |-> ##[1:6] data_oe_o)
    else $error("Read not driven.");
  a_busy_hold: assert property (
    busy_cnt > 8'h10 |-> $stable(display_on_o) && $stable(cursor_on_o)
    && $stable(font_table_select_o))
    else $error("Setting changed while blanking.");
endmodule

bind cod_decoder cod_decoder_props i_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .bus_style_i(bus_style_i), .serial_mode_i(serial_mode_i),
  .chip_select_n_i(chip_select_n_i), .register_select_i(register_select_i),
  .enable_or_read_strobe_i(enable_or_read_strobe_i),
  .rw_or_write_strobe_i(rw_or_write_strobe_i), .data_i(data_i),
  .data_oe_o(data_oe_o), .busy_o(busy_o),
  .address_counter_o(address_counter_o), .glyph_target_o(glyph_target_o),
  .display_shift_o(display_shift_o),
  .increment_direction_o(increment_direction_o),
  .shift_on_access_o(shift_on_access_o), .display_on_o(display_on_o),
  .cursor_on_o(cursor_on_o), .cursor_blink_o(cursor_blink_o),
  .interface_width_o(interface_width_o),
  .line_count_select_o(line_count_select_o),
  .font_size_select_o(font_size_select_o),
  .font_table_select_o(font_table_select_o), .western_set_o(western_set_o));

/* test/cod_host.sv */
`timescale 1ns/1ps
module cod_host (
  input wire logic mclk_i, // Clock.
  output logic chip_select_n_o, // Select, active low.
  output logic register_select_o, // 0 command, 1 data.
  output logic enable_o, // Enable strobe.
  output logic rw_o, // 1 read, 0 write.
  output logic [7:0] data_o, // Host bus level.
  input wire logic [7:0] bus_i, // Device read value.
  input wire logic bus_oe_i // Device drives the bus.
);
  // Idle bus from time zero.
  initial begin
    chip_select_n_o = 1'b1;
    register_select_o = 1'b0;
    enable_o = 1'b0;
    rw_o = 1'b1;
    data_o = 8'h5a;
  end

  // One enable transfer. Setup and hold last four clocks and enable five, at least one over the synchroniser
  // need; a released bus shows the inverted level, never a stale byte.
  task automatic xfer(input logic s, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk_i);
    chip_select_n_o <= 1'b0;
    register_select_o <= s;
    rw_o <= w;
    data_o <= w ? ~data_o : d;
    repeat (4) @(posedge mclk_i);
    enable_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
    q = bus_oe_i ? bus_i : 8'hxx;
    enable_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chip_select_n_o <= 1'b1;
    data_o <= ~data_o;
  endtask

  // Polls status until busy reads low; bounded so a stuck flag still ends.
  task automatic wait_ready(output logic [7:0] q);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b1, 8'h00, q);
      n++;
    end while (q[7] !== 1'b0 && n < 64);
  endtask
endmodule

/* test/char_oled_command_decoder_bench.sv */
`timescale 1ns/1ps
module char_oled_command_decoder_bench;
  logic mclk_i, rst_i, csn, rs, en, rw, oe, busy, glyph, inc, soa;
  logic d_on, c_on, blink, gc, pwr, iw, lc, fs, west, m_g, m_inc;
  logic [7:0] din, dout, rd, pchar;
  logic [6:0] ac, shift, paddr;
  logic [1:0] ft;
  logic [31:0] r;
  logic [7:0] m_text [128];
  logic [7:0] m_glyph [64];
  int n_errors = 0;
  int cmp_count = 0;
  int m_ac, a, i;

  // 50 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  cod_host i_cod_host (.mclk_i(mclk_i), .chip_select_n_o(csn),
    .register_select_o(rs), .enable_o(en), .rw_o(rw), .data_o(din),
    .bus_i(dout), .bus_oe_i(oe));

  // Enable style only; the serial pins stand still.
  cod_decoder i_cod_decoder (.mclk_i(mclk_i), .rst_i(rst_i),
    .bus_style_i(1'b0), .serial_mode_i(1'b0), .chip_select_n_i(csn),
    .register_select_i(rs), .enable_or_read_strobe_i(en),
    .rw_or_write_strobe_i(rw), .data_i(din), .data_o(dout), .data_oe_o(oe),
    .serial_clk_i(1'b0), .serial_data_in_i(1'b0), .serial_data_out_o(),
    .panel_addr_i(paddr), .panel_char_o(pchar), .busy_o(busy),
    .address_counter_o(ac), .glyph_target_o(glyph), .display_shift_o(shift),
    .increment_direction_o(inc), .shift_on_access_o(soa),
    .display_on_o(d_on), .cursor_on_o(c_on), .cursor_blink_o(blink),
    .graphic_char_select_o(gc), .internal_power_on_o(pwr),
    .interface_width_o(iw), .line_count_select_o(lc),
    .font_size_select_o(fs), .font_table_select_o(ft), .western_set_o(west));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Command, then two clocks so its effect lands on the outputs.
  task automatic cmd(input logic [7:0] c);
    i_cod_host.xfer(1'b0, 1'b0, c, rd);
    repeat (2) @(posedge mclk_i);
  endtask

  // Model counter step; glyph addresses wrap in six bits.
  task automatic step;
    m_ac = (m_ac + (m_inc ? 1 : -1)) & (m_g ? 63 : 127);
    repeat (2) @(posedge mclk_i);
    check(ac, m_ac);
  endtask

  task automatic wr(input logic [7:0] d);
    i_cod_host.xfer(1'b1, 1'b0, d, rd);
    if (m_g) begin
      m_glyph[m_ac] = d;
    end else begin
      m_text[m_ac] = d;
    end
    step();
  endtask

  task automatic rdd;
    i_cod_host.xfer(1'b1, 1'b1, 8'h00, rd);
    check(rd, m_g ? m_glyph[m_ac] : m_text[m_ac]);
    step();
  endtask

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    paddr = 7'h00;
    m_inc = 1'b1;
    m_g = 1'b0;
    void'($urandom(32'hb346dd1d));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check({inc, iw, ac, d_on, ft}, {2'b11, 7'h00, 1'b0, 2'h0});
    // Every font table code; the bus stays eight bits wide.
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      cmd({4'h3, r[1:0], i[1:0]});
      check({iw, lc, fs, ft}, {1'b1, r[1:0], i[1:0]});
      check(west, i == 1);
      cmd({5'h01, r[4:2]});
      check({d_on, c_on, blink}, r[4:2]);
      cmd({4'h1, r[6:5], 2'b11});
      check({gc, pwr}, r[6:5]);
    end
    // Four-bit bus: two strobes per byte, high nibble first.
    cmd(8'h2c);
    i_cod_host.xfer(1'b0, 1'b0, 8'h00, rd);
    cmd(8'hd0);
    check({iw, d_on, c_on, blink}, 4'b0101);
    i_cod_host.xfer(1'b0, 1'b0, 8'h30, rd);
    cmd(8'h00);
    check({iw, lc, fs, ft}, 5'b10000);
    // Text writes back to back, status, panel view, read back.
    a = $urandom_range(100, 0);
    m_ac = a;
    cmd(8'h80 | a[7:0]);
    check({glyph, ac}, {1'b0, a[6:0]});
    for (i = 0; i < 4; i++) begin
      r = $urandom;
      wr(r[7:0]);
    end
    i_cod_host.xfer(1'b0, 1'b1, 8'h00, rd);
    check(rd, {1'b0, m_ac[6:0]});
    paddr <= a[6:0];
    repeat (3) @(posedge mclk_i);
    check(pchar, m_text[a]);
    m_ac = a;
    cmd(8'h80 | a[7:0]);
    for (i = 0; i < 4; i++) begin
      rdd();
    end
    // Counting down applies to writes and reads alike.
    cmd(8'h04);
    m_inc = 1'b0;
    check({inc, soa}, 2'b00);
    wr(r[15:8]);
    rdd();
    cmd(8'h06);
    m_inc = 1'b1;
    // Glyph memory at its last cell wraps to zero.
    m_g = 1'b1;
    m_ac = 63;
    cmd(8'h7f);
    check({glyph, ac}, {1'b1, 7'h3f});
    wr(r[23:16]);
    wr(r[31:24]);
    m_ac = 63;
    cmd(8'h7f);
    rdd();
    rdd();
    // Cursor move, display shift, return home with bit 0 low.
    m_g = 1'b0;
    cmd(8'h85);
    cmd(8'h14);
    check(ac, 7'h06);
    cmd(8'h18);
    check(shift, 7'h7f);
    cmd(8'h02);
    check({ac, shift, glyph}, 15'h0000);
    m_ac = a;
    cmd(8'h80 | a[7:0]);
    rdd();
    // Blanking; a command sent meanwhile is dropped.
    cmd(8'h0f);
    cmd(8'h01);
    check(busy, 1'b1);
    cmd(8'h08);
    i_cod_host.xfer(1'b0, 1'b1, 8'h00, rd);
    check(rd[7], 1'b1);
    i_cod_host.wait_ready(rd);
    check({d_on, c_on, blink, rd, inc}, {3'b111, 8'h00, 1'b1});
    m_ac = a;
    m_text[a] = 8'h20;
    cmd(8'h80 | a[7:0]);
    rdd();
    end_of_test();
  end

  // Hang guard; the sequence needs under a thousand clocks.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    end_of_test();
  end
endmodule
